// ==== rcf_pkg.sv ====
package rcf_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] ADDR_CTRL   = 8'h07;
	localparam logic [7:0] ADDR_CHARGE = 8'h08;
	localparam logic [7:0] ADDR_FLAG   = 8'h09;
	localparam int         FLAG_BIT    = 7;
	localparam logic [7:0] CTRL_RST    = 8'h80;
	localparam logic [7:0] CHARGE_RST  = 8'h00;
	localparam logic       FLAG_RST    = 1'b1;
	localparam logic [3:0] CHARGE_KEY  = 4'ha;
	localparam logic [1:0] DIODE_NONE  = 2'h1;
	localparam logic [1:0] DIODE_ONE   = 2'h2;
	localparam logic [1:0] RES_OFF     = 2'h0;

	// ****************************************
	// field layouts
	// ****************************************
	typedef struct packed {
		logic       level;
		logic       test;
		logic       sign;
		logic [4:0] mag;
	} rcf_ctrl_t;

	typedef struct packed {
		logic [3:0] key;
		logic [1:0] diode;
		logic [1:0] res;
	} rcf_charge_t;

	// ****************************************
	// divider and timing
	// ****************************************
	localparam int         PRE_W         = 8;
	localparam int         UPPER_W       = 7;
	localparam logic [7:0] BLANK_CYCLES  = 8'h80;
	localparam int         SQ_W          = 6;
	localparam logic [5:0] SECS_LAST     = 6'h3b;
	localparam logic [5:0] CAL_MINUTES   = 6'h3f;
	localparam logic [6:0] CAL_MAX_MIN   = 7'h3e;
	localparam logic [5:0] CORR_SEC      = 6'h1e;
	localparam int         SYS_CLK_HZ    = 10_000_000;
	localparam int         SYS_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;
	localparam int         OSC_PERIOD_NS = 30518;
	localparam int         STOP_PERIODS  = 4;
	localparam int         STOP_CYCLES   = (STOP_PERIODS * OSC_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int         STOP_W        = 11;

endpackage

// ==== rcf_top.sv ====
`timescale 1ns/1ns
module rcf_top (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       osc_clk_i,
	input  wire logic       reg_wr_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       osc_disable_bit_i,
	output logic      [7:0] reg_rdata_o,
	output logic            square_level_pin_o,
	output logic            charge_enable_o,
	output logic      [1:0] diode_choice_o,
	output logic      [1:0] resistor_choice_o,
	output logic            osc_enable_o,
	output logic            sec_tick_o
);

	// ****************************************
	// system domain registers
	// ****************************************
	rcf_pkg::rcf_ctrl_t       ctrl_reg;
	rcf_pkg::rcf_charge_t     charge_reg;
	logic                     osc_halt_flag_reg;
	logic                     clr_tgl_reg;
	logic               [2:0] hb_sync_reg;
	logic               [1:0] sq_sync_reg;
	logic [rcf_pkg::STOP_W-1:0] idle_cnt_reg;
	logic                     running_reg;
	logic                     dis_prev_reg;
	logic                     boot_reg;
	logic                     wr_ctrl;
	logic                     wr_charge;
	logic                     wr_flag;
	logic                     hb_chg;
	logic                     stop_evt;
	logic                     dis_rise;
	logic                     charge_ok;
	logic                     hb_reg;
	logic [rcf_pkg::SQ_W-1:0] sq_cnt_reg;

	assign wr_ctrl   = reg_wr_i && (reg_addr_i == rcf_pkg::ADDR_CTRL);
	assign wr_charge = reg_wr_i && (reg_addr_i == rcf_pkg::ADDR_CHARGE);
	assign wr_flag   = reg_wr_i && (reg_addr_i == rcf_pkg::ADDR_FLAG);

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_reg <= rcf_pkg::CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_reg <= reg_wdata_i;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			charge_reg <= rcf_pkg::CHARGE_RST;
		end else if (wr_charge) begin
			charge_reg <= reg_wdata_i;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clr_tgl_reg <= 1'b0;
		end else if (wr_ctrl) begin
			clr_tgl_reg <= ~clr_tgl_reg;
		end
	end

	// ****************************************
	// oscillator stop detection
	// ****************************************
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hb_sync_reg <= 3'h0;
			sq_sync_reg <= 2'h0;
		end else begin
			hb_sync_reg <= {hb_sync_reg[1:0], hb_reg};
			sq_sync_reg <= {sq_sync_reg[0], sq_cnt_reg[rcf_pkg::SQ_W-1]};
		end
	end

	assign hb_chg   = hb_sync_reg[2] ^ hb_sync_reg[1];
	assign stop_evt = running_reg && !hb_chg
		&& (idle_cnt_reg == rcf_pkg::STOP_W'(rcf_pkg::STOP_CYCLES - 1));
	assign dis_rise = osc_disable_bit_i && !dis_prev_reg;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			idle_cnt_reg <= '0;
			running_reg  <= 1'b0;
			dis_prev_reg <= 1'b0;
		end else begin
			dis_prev_reg <= osc_disable_bit_i;
			if (hb_chg) begin
				idle_cnt_reg <= '0;
				running_reg  <= 1'b1;
			end else if (stop_evt) begin
				running_reg <= 1'b0;
			end else if (running_reg) begin
				idle_cnt_reg <= idle_cnt_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			osc_halt_flag_reg <= rcf_pkg::FLAG_RST;
		end else if (stop_evt || dis_rise) begin
			osc_halt_flag_reg <= 1'b1;
		end else if (wr_flag && !reg_wdata_i[rcf_pkg::FLAG_BIT]) begin
			osc_halt_flag_reg <= 1'b0;
		end
	end

	// ****************************************
	// outputs and readback
	// ****************************************
	// unlock key, diode code, resistor code
	assign charge_ok = (charge_reg.key == rcf_pkg::CHARGE_KEY)
		&& (charge_reg.diode == rcf_pkg::DIODE_NONE || charge_reg.diode == rcf_pkg::DIODE_ONE)
		&& (charge_reg.res != rcf_pkg::RES_OFF);

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			charge_enable_o   <= 1'b0;
			diode_choice_o    <= 2'h0;
			resistor_choice_o <= 2'h0;
		end else begin
			charge_enable_o   <= charge_ok;
			diode_choice_o    <= charge_ok ? charge_reg.diode : 2'h0;
			resistor_choice_o <= charge_ok ? charge_reg.res : 2'h0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			square_level_pin_o <= 1'b1;
			osc_enable_o       <= 1'b1;
			boot_reg           <= 1'b0;
		end else begin
			square_level_pin_o <= ctrl_reg.test ? sq_sync_reg[1] : ctrl_reg.level;
			osc_enable_o       <= !osc_disable_bit_i;
			boot_reg           <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else begin
			unique case (reg_addr_i)
				rcf_pkg::ADDR_CTRL:   reg_rdata_o <= ctrl_reg;
				rcf_pkg::ADDR_CHARGE: reg_rdata_o <= charge_reg;
				rcf_pkg::ADDR_FLAG:   reg_rdata_o <= {osc_halt_flag_reg, 7'h00};
				default:              reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// ****************************************
	// oscillator domain
	// ****************************************
	logic                       [1:0] dis_sync_reg;
	logic                       [5:0] trim_s1_reg;
	logic                       [5:0] trim_s2_reg;
	logic                       [2:0] clr_sync_reg;
	logic        [rcf_pkg::PRE_W-1:0] pre_reg;
	logic      [rcf_pkg::UPPER_W-1:0] upper_reg;
	logic                       [7:0] blank_reg;
	logic                             pend_reg;
	logic                       [5:0] sec_reg;
	logic                       [5:0] min_reg;
	logic                             div_clr;
	logic                             trim_sign;
	logic                       [4:0] trim_magnitude;
	logic                             stage_wrap;
	logic                             insert_now;
	logic        [rcf_pkg::UPPER_W:0] upper_sum;
	logic                             sec_carry;
	logic                       [5:0] sec_next;
	logic                             corr_min;

	always_ff @(posedge osc_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dis_sync_reg <= 2'h0;
			trim_s1_reg  <= 6'h00;
			trim_s2_reg  <= 6'h00;
			clr_sync_reg <= 3'h0;
		end else begin
			dis_sync_reg <= {dis_sync_reg[0], osc_disable_bit_i};
			// trim word taken with the clear strobe, long after it settled
			if (div_clr) begin
				trim_s1_reg <= {ctrl_reg.sign, ctrl_reg.mag};
			end
			trim_s2_reg  <= trim_s1_reg;
			clr_sync_reg <= {clr_sync_reg[1:0], clr_tgl_reg};
		end
	end

	assign trim_sign      = trim_s2_reg[5];
	assign trim_magnitude = trim_s2_reg[4:0];
	assign div_clr        = clr_sync_reg[2] ^ clr_sync_reg[1];

	// test counter ignores trim, 50 percent duty
	always_ff @(posedge osc_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hb_reg     <= 1'b0;
			sq_cnt_reg <= '0;
		end else if (div_clr) begin
			sq_cnt_reg <= '0;
		end else if (!dis_sync_reg[1]) begin
			hb_reg     <= ~hb_reg;
			sq_cnt_reg <= sq_cnt_reg + 1'b1;
		end
	end

	assign stage_wrap = (blank_reg == 8'h00) && (pre_reg == {rcf_pkg::PRE_W{1'b1}});
	assign insert_now = stage_wrap && pend_reg && trim_sign;
	assign upper_sum  = {1'b0, upper_reg} + (insert_now ? 8'h02 : 8'h01);
	assign sec_carry  = stage_wrap && upper_sum[rcf_pkg::UPPER_W];
	assign sec_next   = (sec_reg == rcf_pkg::SECS_LAST) ? 6'h00 : sec_reg + 1'b1;
	assign corr_min   = ({1'b0, min_reg} < {1'b0, trim_magnitude, 1'b0})
		&& ({1'b0, min_reg} < rcf_pkg::CAL_MAX_MIN);

	always_ff @(posedge osc_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pre_reg    <= '0;
			upper_reg  <= '0;
			blank_reg  <= 8'h00;
			pend_reg   <= 1'b0;
			sec_tick_o <= 1'b0;
		end else if (div_clr) begin
			pre_reg    <= '0;
			upper_reg  <= '0;
			blank_reg  <= 8'h00;
			pend_reg   <= 1'b0;
			sec_tick_o <= 1'b0;
		end else if (dis_sync_reg[1]) begin
			sec_tick_o <= 1'b0;
		end else begin
			sec_tick_o <= sec_carry;
			if (blank_reg != 8'h00) begin
				blank_reg <= blank_reg - 1'b1;
			end else begin
				pre_reg <= pre_reg + 1'b1;
			end
			if (stage_wrap) begin
				upper_reg <= upper_sum[rcf_pkg::UPPER_W-1:0];
				if (pend_reg) begin
					pend_reg <= 1'b0;
					if (!trim_sign) begin
						blank_reg <= rcf_pkg::BLANK_CYCLES;
					end
				end
			end
			if (sec_carry && sec_next == rcf_pkg::CORR_SEC && corr_min) begin
				pend_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge osc_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sec_reg <= 6'h00;
			min_reg <= 6'h00;
		end else if (div_clr) begin
			sec_reg <= 6'h00;
			min_reg <= 6'h00;
		end else if (!dis_sync_reg[1] && sec_carry) begin
			sec_reg <= sec_next;
			if (sec_reg == rcf_pkg::SECS_LAST) begin
				min_reg <= (min_reg == rcf_pkg::CAL_MINUTES) ? 6'h00 : min_reg + 1'b1;
			end
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	sequence s_flag_clear_wr;
		wr_flag && !reg_wdata_i[rcf_pkg::FLAG_BIT] && !stop_evt && !dis_rise;
	endsequence

	sequence s_stop_seen;
		stop_evt || dis_rise;
	endsequence

	a_pin_static_level: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!ctrl_reg.test |=> square_level_pin_o == $past(ctrl_reg.level))
		else $error("pin does not follow static level");

	a_pin_test_wave: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		ctrl_reg.test |=> square_level_pin_o == $past(sq_sync_reg[1]))
		else $error("pin does not follow test wave");

	a_boot_values: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!boot_reg |-> ctrl_reg == rcf_pkg::CTRL_RST && charge_reg == rcf_pkg::CHARGE_RST
		&& osc_halt_flag_reg)
		else $error("wrong power-up register values");

	a_charge_unlock: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		charge_enable_o |-> $past(charge_reg.key) == rcf_pkg::CHARGE_KEY
		&& $past(charge_reg.res) != rcf_pkg::RES_OFF)
		else $error("charger enabled without key");

	a_charge_diode: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		charge_ok |=> charge_enable_o && diode_choice_o == $past(charge_reg.diode))
		else $error("charger decode wrong");

	a_flag_stop_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_stop_seen |=> osc_halt_flag_reg)
		else $error("halt flag not set on stop");

	a_flag_hold_one: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		osc_halt_flag_reg && !(wr_flag && !reg_wdata_i[rcf_pkg::FLAG_BIT]) |=> osc_halt_flag_reg)
		else $error("halt flag dropped without write");

	a_flag_clear_wr: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_flag_clear_wr |=> !osc_halt_flag_reg)
		else $error("halt flag not cleared");

	a_flag_low_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$past(reg_addr_i) == rcf_pkg::ADDR_FLAG |-> reg_rdata_o[6:0] == 7'h00)
		else $error("flag low bits not zero");

	a_ctrl_readback: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		wr_ctrl ##1 reg_addr_i == rcf_pkg::ADDR_CTRL |=> reg_rdata_o == $past(reg_wdata_i, 2))
		else $error("control readback wrong");

	a_div_clear: assert property (@(posedge osc_clk_i) disable iff (!rst_n_i)
		div_clr |=> pre_reg == '0 && upper_reg == '0 && sec_reg == 6'h00)
		else $error("divider not cleared");

	a_trim_window: assert property (@(posedge osc_clk_i) disable iff (!rst_n_i)
		$rose(pend_reg) |-> min_reg < {trim_magnitude, 1'b0} && min_reg < 6'h3e)
		else $error("correction outside window");

	a_blank_len: assert property (@(posedge osc_clk_i) disable iff (!rst_n_i)
		stage_wrap && pend_reg && !trim_sign && !div_clr && !dis_sync_reg[1]
		|=> blank_reg == rcf_pkg::BLANK_CYCLES)
		else $error("blank length wrong");

endmodule // rcf_top

// ==== rcf_host_model.sv ====
`timescale 1ns/1ns
// ****************************************
// host register master
// ****************************************
module rcf_host_model (
	input  wire logic       sys_clk_i,
	input  wire logic [7:0] reg_rdata_i,
	output logic            reg_wr_o,
	output logic      [7:0] reg_addr_o,
	output logic      [7:0] reg_wdata_o
);
	initial begin
		reg_wr_o    = 1'b0;
		reg_addr_o  = 8'h00;
		reg_wdata_o = 8'h00;
	end

	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(negedge sys_clk_i);
		reg_wr_o    = 1'b1;
		reg_addr_o  = addr;
		reg_wdata_o = data;
		@(negedge sys_clk_i);
		reg_wr_o    = 1'b0;
		reg_wdata_o = ~data;
	endtask

	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		@(negedge sys_clk_i);
		reg_addr_o = addr;
		@(negedge sys_clk_i);
		data = reg_rdata_i;
	endtask
endmodule // rcf_host_model

// ==== test_rtc_control_calibration_flags.sv ====
`timescale 1ns/1ns
module test_rtc_control_calibration_flags;
	typedef struct packed {
		logic [7:0] data;
		logic       en;
		logic [1:0] dio;
		logic [1:0] res;
	} rcf_row_t;

	logic       sys_clk_i = 1'b0;
	logic       osc_clk_i = 1'b0;
	logic       osc_run   = 1'b1;
	logic       rst_n_i   = 1'b0;
	logic       osc_disable_bit_i = 1'b0;
	logic       reg_wr_i;
	logic [7:0] reg_addr_i;
	logic [7:0] reg_wdata_i;
	logic [7:0] reg_rdata_o;
	logic       square_level_pin_o;
	logic       charge_enable_o;
	logic [1:0] diode_choice_o;
	logic [1:0] resistor_choice_o;
	logic       osc_enable_o;
	logic       sec_tick_o;
	logic [7:0] rd;
	int         failures   = 0;
	int         num_checks = 0;
	int         n;

	localparam rcf_row_t rows [10] = '{
		'{8'ha5, 1'b1, 2'h1, 2'h1}, '{8'ha9, 1'b1, 2'h2, 2'h1},
		'{8'ha6, 1'b1, 2'h1, 2'h2}, '{8'haa, 1'b1, 2'h2, 2'h2},
		'{8'ha7, 1'b1, 2'h1, 2'h3}, '{8'hab, 1'b1, 2'h2, 2'h3},
		'{8'ha4, 1'b0, 2'h0, 2'h0}, '{8'ha1, 1'b0, 2'h0, 2'h0},
		'{8'had, 1'b0, 2'h0, 2'h0}, '{8'h55, 1'b0, 2'h0, 2'h0}
	};

	always #50 sys_clk_i = ~sys_clk_i;

	initial begin
		#37;
		forever begin
			#80;
			if (osc_run) begin
				osc_clk_i = ~osc_clk_i;
			end
		end
	end

	rcf_top u_dut (
		.sys_clk_i          (sys_clk_i),
		.rst_n_i            (rst_n_i),
		.osc_clk_i          (osc_clk_i),
		.reg_wr_i           (reg_wr_i),
		.reg_addr_i         (reg_addr_i),
		.reg_wdata_i        (reg_wdata_i),
		.osc_disable_bit_i  (osc_disable_bit_i),
		.reg_rdata_o        (reg_rdata_o),
		.square_level_pin_o (square_level_pin_o),
		.charge_enable_o    (charge_enable_o),
		.diode_choice_o     (diode_choice_o),
		.resistor_choice_o  (resistor_choice_o),
		.osc_enable_o       (osc_enable_o),
		.sec_tick_o         (sec_tick_o)
	);

	rcf_host_model u_host (
		.sys_clk_i   (sys_clk_i),
		.reg_rdata_i (reg_rdata_o),
		.reg_wr_o    (reg_wr_i),
		.reg_addr_o  (reg_addr_i),
		.reg_wdata_o (reg_wdata_i)
	);

	// ****************************************
	// compare and closing tasks
	// ****************************************
	task automatic fail_msg(input string what);
		failures++;
		$display("CHECK FAILED t=%0t %s", $time, what);
	endtask

	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			fail_msg($sformatf("%s got %h exp %h", what, got, exp));
		end
	endtask

	task automatic check_bits(input logic [1:0] got, input logic [1:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			fail_msg($sformatf("%s got %b exp %b", what, got, exp));
		end
	endtask

	task automatic check_range(input int got, input int lo, input int hi, input string what);
		num_checks++;
		if (got < lo || got > hi) begin
			fail_msg($sformatf("%s got %0d", what, got));
		end
	endtask

	task automatic read_check(input logic [7:0] addr, input logic [7:0] exp);
		u_host.read_reg(addr, rd);
		check_byte(rd, exp, $sformatf("read %h", addr));
	endtask

	task automatic count_toggles(input int cycles, output int cnt);
		logic prev;
		cnt = 0;
		prev = square_level_pin_o;
		repeat (cycles) begin
			@(negedge sys_clk_i);
			if (square_level_pin_o !== prev) begin
				cnt++;
			end
			prev = square_level_pin_o;
		end
	endtask

	task automatic finish_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#(90000 * 100);
		fail_msg("timeout");
		finish_test();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (10) @(negedge sys_clk_i);
		rst_n_i = 1'b1;
		check_bits({1'b0, square_level_pin_o}, 2'h1, "pin reset");
		check_bits({1'b0, charge_enable_o}, 2'h0, "charge reset");
		read_check(8'h07, 8'h80);
		read_check(8'h08, 8'h00);
		read_check(8'h09, 8'h80);
		read_check(8'h0a, 8'h00);
		foreach (rows[i]) begin
			u_host.write_reg(8'h08, rows[i].data);
			read_check(8'h08, rows[i].data);
			check_bits({1'b0, charge_enable_o}, {1'b0, rows[i].en}, "charge en");
			check_bits(diode_choice_o, rows[i].dio, "diode");
			check_bits(resistor_choice_o, rows[i].res, "resistor");
		end
		u_host.write_reg(8'h07, 8'h1f);
		read_check(8'h07, 8'h1f);
		check_bits({1'b0, square_level_pin_o}, 2'h0, "pin low");
		u_host.write_reg(8'h07, 8'hbf);
		read_check(8'h07, 8'hbf);
		check_bits({1'b0, square_level_pin_o}, 2'h1, "pin high");
		u_host.write_reg(8'h07, 8'h40);
		count_toggles(410, n);
		check_range(n, 7, 9, "wave toggles");
		u_host.write_reg(8'h07, 8'h7f);
		count_toggles(410, n);
		check_range(n, 7, 9, "trimmed wave toggles");
		u_host.write_reg(8'h07, 8'h80);
		n = 0;
		while (sec_tick_o !== 1'b1 && n < 60000) begin
			@(negedge sys_clk_i);
			n++;
		end
		check_range(n, 52400, 52460, "first second");
		u_host.write_reg(8'h09, 8'h00);
		read_check(8'h09, 8'h00);
		u_host.write_reg(8'h09, 8'hff);
		read_check(8'h09, 8'h00);
		@(negedge sys_clk_i);
		osc_disable_bit_i = 1'b1;
		repeat (3) @(negedge sys_clk_i);
		check_bits({1'b0, osc_enable_o}, 2'h0, "osc stopped");
		read_check(8'h09, 8'h80);
		osc_disable_bit_i = 1'b0;
		repeat (3) @(negedge sys_clk_i);
		check_bits({1'b0, osc_enable_o}, 2'h1, "osc running");
		u_host.write_reg(8'h09, 8'h00);
		read_check(8'h09, 8'h00);
		osc_run = 1'b0;
		repeat (1300) @(negedge sys_clk_i);
		read_check(8'h09, 8'h80);
		osc_run = 1'b1;
		repeat (20) @(negedge sys_clk_i);
		u_host.write_reg(8'h09, 8'h00);
		repeat (20) @(negedge sys_clk_i);
		read_check(8'h09, 8'h00);
		finish_test();
	end
endmodule // test_rtc_control_calibration_flags
